// ==== inc/sscp_pkg.sv ====
// Shared constants and types for the serial setup chain port
package sscp_pkg;
	localparam int unsigned SETUP_BITS_DEF  = 32'h0000_0040;
	localparam int unsigned SYNC_STAGES     = 32'h0000_0002;
	localparam logic        DONE_N_RESET    = 1'h1;
	localparam logic        PASS_RESET      = 1'h0;
	localparam logic        SCLK_RESET      = 1'h0;
	localparam logic        LOAD_EN_N_RESET = 1'h1;

	typedef enum logic [0:0] {
		SSCP_LOADING = 1'b0,
		SSCP_DONE    = 1'b1
	} sscp_state_t;

	typedef struct packed {
		logic sclk;
		logic data;
		logic load_en_n;
	} sscp_serial_t;
endpackage

// ==== core/sscp_sync.sv ====
// Two flip-flop synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
module sscp_sync #(
	parameter int unsigned WIDTH = 3,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	// Clock and reset
	input  wire logic             clk_in,
	input  wire logic             rst_n_in,
	// Data
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			meta_q   <= RESET_VAL;
			sync_out <= RESET_VAL;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule

// ==== core/sscp_top.sv ====
// Serial setup chain port: shifts setup bits, then passes the chain through
`timescale 1ns/1ps
// Operation
// - Capture serial bit on clock rise, enable low
// - Setup state held in a shift register
// - After done, serial input passes to output
// - Pass-through output carries data down chain
// - Once complete, done output follows load enable
// - Done low means queue traffic may begin
module sscp_top #(
	parameter int unsigned SETUP_BITS = sscp_pkg::SETUP_BITS_DEF
) (
	// Clock and reset
	input  wire logic                  core_clk_in,
	input  wire logic                  reset_n_in,
	// Serial chain inputs
	input  wire logic                  setup_sclk_in,
	input  wire logic                  setup_data_in,
	input  wire logic                  chain_load_enable_n_in,
	// Serial chain outputs
	output logic                       setup_pass_out,
	output logic                       chain_load_done_n_out,
	// Configuration state
	output logic [SETUP_BITS-1:0]      setup_word_out,
	output logic                       setup_ready_out
);
	localparam int unsigned CW = $clog2(SETUP_BITS + 1);
	localparam logic [CW-1:0] LAST_CNT = CW'(SETUP_BITS - 1);

	logic [1:0]             rst_sync_q;
	logic                   rst_n;
	sscp_pkg::sscp_serial_t pin_raw;
	sscp_pkg::sscp_serial_t pin_s;
	logic                   sclk_prev_q;
	logic                   sclk_rise;
	logic                   accept;
	logic [CW-1:0]          count_q;
	sscp_pkg::sscp_state_t  state_q;
	logic [SETUP_BITS-1:0]  word_q;
	logic                   done_n_q;
	logic                   pass_q;
	logic                   ready_q;

	// Completion decode, shared by the ready, done and pass flops and the checks
	function automatic logic is_done(input sscp_pkg::sscp_state_t st);
		return (st == sscp_pkg::SSCP_DONE);
	endfunction

	// Reset release through two flops
	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	assign pin_raw = '{sclk: setup_sclk_in, data: setup_data_in, load_en_n: chain_load_enable_n_in};

	sscp_sync #(
		.WIDTH     (3),
		.RESET_VAL ({sscp_pkg::SCLK_RESET, sscp_pkg::PASS_RESET, sscp_pkg::LOAD_EN_N_RESET})
	) u_sync (
		.clk_in   (core_clk_in),
		.rst_n_in (rst_n),
		.async_in (pin_raw),
		.sync_out (pin_s)
	);

	// Edge detect on the synchronised copy only
	always_ff @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			sclk_prev_q <= sscp_pkg::SCLK_RESET;
		end else begin
			sclk_prev_q <= pin_s.sclk;
		end
	end
	assign sclk_rise = pin_s.sclk & ~sclk_prev_q;
	assign accept    = sclk_rise & ~pin_s.load_en_n & (state_q == sscp_pkg::SSCP_LOADING);

	// Setup shift register, newest bit at the top
	always_ff @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			word_q <= '0;
		end else if (accept) begin
			if (SETUP_BITS > 1) begin
				word_q <= {pin_s.data, word_q[SETUP_BITS-1:1]};
			end else begin
				word_q <= {SETUP_BITS{pin_s.data}};
			end
		end
	end

	// Bit counter and completion
	always_ff @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			count_q <= '0;
			state_q <= sscp_pkg::SSCP_LOADING;
		end else if (accept) begin
			count_q <= CW'(count_q + 1'b1);
			unique case (state_q)
				sscp_pkg::SSCP_LOADING: begin
					if (count_q == LAST_CNT) begin
						state_q <= sscp_pkg::SSCP_DONE;
					end
				end
				sscp_pkg::SSCP_DONE: begin
					state_q <= sscp_pkg::SSCP_DONE;
				end
			endcase
		end
	end

	// Ready flag for the rest of the device, a plain level
	always_ff @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			ready_q <= 1'b0;
		end else begin
			ready_q <= is_done(state_q);
		end
	end

	// Done output held high until complete, then a copy of the enable
	always_ff @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			done_n_q <= sscp_pkg::DONE_N_RESET;
		end else if (is_done(state_q)) begin
			done_n_q <= pin_s.load_en_n;
		end else begin
			done_n_q <= sscp_pkg::DONE_N_RESET;
		end
	end

	// Pass-through adds the synchroniser latency, a limit for fast chains
	always_ff @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			pass_q <= sscp_pkg::PASS_RESET;
		end else if (is_done(state_q) && !done_n_q) begin
			pass_q <= pin_s.data;
		end else begin
			pass_q <= sscp_pkg::PASS_RESET;
		end
	end

	// Every output is a flop, nothing after it
	assign setup_word_out        = word_q;
	assign setup_ready_out       = ready_q;
	assign chain_load_done_n_out = done_n_q;
	assign setup_pass_out        = pass_q;

	a_no_early_done: assert property (@(posedge core_clk_in) disable iff (!rst_n)
		!is_done(state_q) |=> done_n_q)
		else $error("done asserted before load complete");

	a_done_follows: assert property (@(posedge core_clk_in) disable iff (!rst_n)
		is_done(state_q) |=> (done_n_q == $past(pin_s.load_en_n)))
		else $error("done does not follow load enable");

	a_done_release: assert property (@(posedge core_clk_in) disable iff (!rst_n)
		(is_done(state_q) && pin_s.load_en_n) |=> done_n_q)
		else $error("done stays low with enable high");

	a_done_low: assert property (@(posedge core_clk_in) disable iff (!rst_n)
		(is_done(state_q) && !pin_s.load_en_n) |=> !done_n_q)
		else $error("done not low after programming");

	a_shift_step: assert property (@(posedge core_clk_in) disable iff (!rst_n)
		(accept && SETUP_BITS > 1) |=> (word_q[SETUP_BITS-1] == $past(pin_s.data)))
		else $error("shift register did not take bit");

	a_shift_older: assert property (@(posedge core_clk_in) disable iff (!rst_n)
		accept |=> ((word_q << 1) == (($past(word_q) >> 1) << 1)))
		else $error("older setup bits did not move down");

	a_hold_idle: assert property (@(posedge core_clk_in) disable iff (!rst_n)
		!accept |=> $stable(word_q))
		else $error("setup changed without accepted bit");

	a_no_accept_high: assert property (@(posedge core_clk_in) disable iff (!rst_n)
		pin_s.load_en_n |=> $stable(word_q))
		else $error("bit accepted with enable high");

	a_frozen_done: assert property (@(posedge core_clk_in) disable iff (!rst_n)
		is_done(state_q) |=> $stable(word_q))
		else $error("setup changed after completion");

	a_single_accept: assert property (@(posedge core_clk_in) disable iff (!rst_n)
		accept |=> !accept)
		else $error("one clock rise taken twice");

	a_pass_data: assert property (@(posedge core_clk_in) disable iff (!rst_n)
		(is_done(state_q) && !done_n_q) |=> (pass_q == $past(pin_s.data)))
		else $error("pass-through wrong");

	a_pass_gated: assert property (@(posedge core_clk_in) disable iff (!rst_n)
		done_n_q |=> !pass_q)
		else $error("pass-through active with done high");

	a_pass_quiet: assert property (@(posedge core_clk_in) disable iff (!rst_n)
		!is_done(state_q) |=> !pass_q)
		else $error("pass-through active while loading");

	a_done_sticky: assert property (@(posedge core_clk_in) disable iff (!rst_n)
		is_done(state_q) |=> (is_done(state_q))[*2])
		else $error("completion lost");

	a_count_step: assert property (@(posedge core_clk_in) disable iff (!rst_n)
		accept |=> (count_q == CW'($past(count_q) + 1'b1)))
		else $error("bit count did not advance");

	a_count_hold: assert property (@(posedge core_clk_in) disable iff (!rst_n)
		!accept |=> $stable(count_q))
		else $error("bit count moved without a bit");

	a_count_range: assert property (@(posedge core_clk_in) disable iff (!rst_n)
		!is_done(state_q) |-> (count_q < CW'(SETUP_BITS)))
		else $error("bit count past chain length while loading");

	a_done_at_count: assert property (@(posedge core_clk_in) disable iff (!rst_n)
		(accept && count_q == LAST_CNT) |=> is_done(state_q))
		else $error("last bit did not complete loading");

	a_stay_loading: assert property (@(posedge core_clk_in) disable iff (!rst_n)
		(!is_done(state_q) && !(accept && count_q == LAST_CNT)) |=> !is_done(state_q))
		else $error("loading completed early");

	a_ready_set: assert property (@(posedge core_clk_in) disable iff (!rst_n)
		is_done(state_q) |=> ready_q)
		else $error("ready missing after completion");

	a_ready_clear: assert property (@(posedge core_clk_in) disable iff (!rst_n)
		!is_done(state_q) |=> !ready_q)
		else $error("ready high while loading");
endmodule

// ==== dv/sscp_prog_model.sv ====
// Programming controller model that drives the serial setup pins
`timescale 1ns/1ps
module sscp_prog_model (
	// Clock
	input  wire logic clk_in,
	// Serial pins
	output logic      sclk_out,
	output logic      data_out,
	output logic      en_n_out
);
	// Shift clock idles low between bits, as a real controller leaves it
	initial begin
		sclk_out = 1'h0;
		data_out = 1'h0;
		en_n_out = 1'h1;
	end
	// Data set half a bit early and held across the rise
	task automatic send_bit(input logic b);
		@(posedge clk_in) data_out <= b;
		repeat (8) @(posedge clk_in);
		sclk_out <= 1'h1;
		repeat (8) @(posedge clk_in);
		sclk_out <= 1'h0;
	endtask
	task automatic set_pins(input logic en_n, input logic d);
		@(posedge clk_in) en_n_out <= en_n;
		data_out <= d;
		repeat (8) @(posedge clk_in);
	endtask
endmodule

// ==== dv/tb_top.sv ====
// Testbench for the serial setup chain port
`timescale 1ns/1ps
module tb_top;
	localparam int unsigned NB = 32'h0000_0004;
	logic          clk = 1'h0;
	logic          rst_n = 1'h0;
	logic          sclk;
	logic          sdata;
	logic          en_n;
	logic          pass;
	logic          done_n;
	logic [NB-1:0] word;
	logic          ready;
	logic [NB-1:0] w = '0;
	int            error_cnt = 0;
	int            n_compared = 0;
	always #5 clk = ~clk;
	sscp_prog_model prog (.clk_in(clk), .sclk_out(sclk), .data_out(sdata), .en_n_out(en_n));
	sscp_top #(.SETUP_BITS(NB)) dut (.core_clk_in(clk), .reset_n_in(rst_n), .setup_sclk_in(sclk),
		.setup_data_in(sdata), .chain_load_enable_n_in(en_n), .setup_pass_out(pass),
		.chain_load_done_n_out(done_n), .setup_word_out(word), .setup_ready_out(ready));
	task automatic chk(input string what, input logic [NB-1:0] seen, input logic [NB-1:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic test_refused();
		prog.set_pins(1'h1, 1'h0);
		prog.send_bit(1'h1);
		chk("word", word, '0);
		chk("done_n", done_n, 1'h1);
		$display("test refused ended");
	endtask
	task automatic test_load();
		logic [NB-1:0] pat;
		pat = 4'hD;
		prog.set_pins(1'h0, 1'h0);
		for (int i = 0; i < NB; i++) begin
			prog.send_bit(pat[i]);
			w = {pat[i], w[NB-1:1]};
			chk("word", word, w);
			chk("ready", ready, i == NB - 1);
			chk("done_n", done_n, i != NB - 1);
		end
		$display("test load ended");
	endtask
	task automatic test_pass();
		prog.send_bit(1'h0);
		chk("word", word, w);
		for (int v = 0; v < 2; v++) begin
			prog.set_pins(1'h0, v[0]);
			chk("pass", pass, v[0]);
		end
		prog.set_pins(1'h1, 1'h1);
		chk("done_n", done_n, 1'h1);
		chk("pass", pass, 1'h0);
		$display("test pass ended");
	endtask
	task automatic test_reset();
		prog.set_pins(1'h0, 1'h1);
		chk("done_n", done_n, 1'h0);
		chk("pass", pass, 1'h1);
		@(posedge clk) rst_n <= 1'h0;
		repeat (3) @(posedge clk);
		chk("word", word, '0);
		chk("done_n", done_n, 1'h1);
		chk("ready", ready, 1'h0);
		chk("pass", pass, 1'h0);
		@(posedge clk) rst_n <= 1'h1;
		repeat (6) @(posedge clk);
		prog.set_pins(1'h0, 1'h0);
		prog.send_bit(1'h1);
		chk("word", word, {1'h1, {(NB - 1){1'h0}}});
		chk("done_n", done_n, 1'h1);
		chk("ready", ready, 1'h0);
		chk("pass", pass, 1'h0);
		$display("test reset ended");
	endtask
	task automatic test_done();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'h1;
		repeat (6) @(posedge clk);
		test_refused();
		test_load();
		test_pass();
		test_reset();
		test_done();
	end
	// Whole run is about 200 core cycles; this leaves ample margin
	initial begin
		#20000;
		error_cnt++;
		test_done();
	end
endmodule
